//--- hdl/duty_scaler.sv
`timescale 1ns/1ps
`include "launch_map.svh"
module duty_scaler (
	// clock
	input wire logic clk,
	input wire logic reset_n,
	// command
	input wire logic [1:0] ref_mode,
	input wire logic [15:0] duty_cmd,
	input wire logic [15:0] min_duty,
	input wire logic [15:0] power_full_scale,
	input wire logic [15:0] current_full_scale,
	// result
	output logic [15:0] reference,
	output logic ref_zero
);
	function automatic logic [15:0] scale(input logic [15:0] d,
		input logic [15:0] fs);
		logic [31:0] p;
		p = 32'h0;
		p = d * fs;
		return p[31:16];
	endfunction

	logic [15:0] nxt_ref;
	logic [15:0] d_eff;
	logic [15:0] reference_ff;
	always_comb begin
		d_eff = (duty_cmd < min_duty) ? min_duty : duty_cmd;
		nxt_ref = 16'h0;
		case (ref_mode)
			`MODE_POWER: begin
				if (power_full_scale == 16'h0)
					nxt_ref = 16'h0;
				else if (d_eff == `DUTY_FULL)
					nxt_ref = power_full_scale;
				else
					nxt_ref = scale(d_eff, power_full_scale);
			end
			`MODE_VOLTAGE: begin
				if (duty_cmd < min_duty)
					nxt_ref = 16'h0;
				else
					nxt_ref = duty_cmd;
			end
			`MODE_CURRENT: begin
				if (d_eff == `DUTY_FULL)
					nxt_ref = current_full_scale;
				else
					nxt_ref = scale(d_eff, current_full_scale);
			end
			default: nxt_ref = 16'h0;
		endcase
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			reference_ff <= 16'h0;
		else
			reference_ff <= nxt_ref;
	end
	assign reference = reference_ff;
	assign ref_zero = (reference_ff == 16'h0);

	power_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
		ref_mode == `MODE_POWER && power_full_scale == 16'h0
		|=> reference == 16'h0)
		else $error("power reference not forced to zero");
	volt_low_a: assert property (@(posedge clk) disable iff (!reset_n)
		ref_mode == `MODE_VOLTAGE && duty_cmd < min_duty
		|=> reference == 16'h0)
		else $error("voltage not zero below minimum duty");
	curr_full_a: assert property (@(posedge clk) disable iff (!reset_n)
		ref_mode == `MODE_CURRENT && duty_cmd == `DUTY_FULL
		|=> reference == $past(current_full_scale))
		else $error("current reference not at limit");
endmodule

//--- hdl/launch_sequencer.sv
`timescale 1ns/1ps
`include "launch_map.svh"
module launch_sequencer (
	// clock
	input wire logic clk,
	input wire logic reset_n,
	// duty command and scaling
	input wire logic [1:0] ref_mode,
	input wire logic [15:0] duty_cmd,
	input wire logic [15:0] min_duty,
	input wire logic [15:0] power_full_scale,
	input wire logic [15:0] current_full_scale,
	// low power
	input wire logic low_power_select,
	input wire logic speed_wake_pin,
	// direction
	input wire logic dir_change_cmd,
	input wire logic reversal_path_select,
	// configuration
	input wire logic initial_detect_enable,
	input wire logic resync_enable,
	input wire logic reversal_drive_enable,
	input wire logic coast_enable,
	input wire logic brake_enable,
	input wire logic brake_type_select,
	input wire logic brake_side_select,
	input wire logic [1:0] launch_method_select,
	input wire logic [15:0] coast_duration,
	input wire logic [15:0] brake_duration,
	input wire logic [15:0] brake_settle_window,
	// measurement
	input wire logic [15:0] bemf_level,
	input wire logic [15:0] standstill_bemf_threshold,
	input wire logic spin_forward,
	input wire logic [15:0] motor_speed,
	input wire logic [15:0] forward_catch_speed_threshold,
	input wire logic [15:0] loop_handoff_speed,
	input wire logic [15:0] brake_current_threshold,
	input wire logic [15:0] phase_current_max,
	input wire logic load_done,
	// results
	output logic [15:0] reference,
	output launch_pkg::seq_state_t state,
	output launch_pkg::bridge_t bridge_mode,
	output logic [1:0] launch_method,
	output logic sleep_mode,
	output logic standby_mode,
	output logic sensing
);
	////////////////////////////////////////////////////////////////////
	logic ref_zero;
	duty_scaler scaler (
		.clk(clk),
		.reset_n(reset_n),
		.ref_mode(ref_mode),
		.duty_cmd(duty_cmd),
		.min_duty(min_duty),
		.power_full_scale(power_full_scale),
		.current_full_scale(current_full_scale),
		.reference(reference),
		.ref_zero(ref_zero)
	);

	////////////////////////////////////////////////////////////////////
	// pin from outside domain: three flops, accept when last two agree
	logic [2:0] wake_sync_ff;
	logic wake_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			wake_sync_ff <= 3'h0;
		else
			wake_sync_ff <= {wake_sync_ff[1:0], speed_wake_pin};
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			wake_ff <= 1'b0;
		else if (wake_sync_ff[1] == wake_sync_ff[2])
			wake_ff <= wake_sync_ff[2];
	end

	////////////////////////////////////////////////////////////////////
	launch_pkg::seq_state_t state_ff, nxt_state;
	logic [15:0] timer_ff;
	logic [15:0] settle_ff;
	logic [7:0] load_cnt_ff;
	logic [1:0] align_pass_ff;
	logic stopped;
	logic enter;

	// zero full-scale power keeps the motor parked
	assign stopped = ref_zero ||
		(ref_mode == `MODE_POWER && power_full_scale == 16'h0);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			launch_pkg::st_power_on:
				if (load_done && load_cnt_ff == `LOAD_CYCLES)
					nxt_state = launch_pkg::st_sleep;
			launch_pkg::st_sleep:
				if (!stopped)
					nxt_state = launch_pkg::st_detect_en;
			launch_pkg::st_detect_en:
				nxt_state = initial_detect_enable ?
					launch_pkg::st_sense : launch_pkg::st_brake_en;
			launch_pkg::st_sense:
				nxt_state = (bemf_level < standstill_bemf_threshold) ?
					launch_pkg::st_brake_en : launch_pkg::st_spin_dir;
			launch_pkg::st_spin_dir:
				nxt_state = spin_forward ?
					launch_pkg::st_resync_en : launch_pkg::st_rev_en;
			launch_pkg::st_resync_en:
				nxt_state = resync_enable ?
					launch_pkg::st_resync_spd : launch_pkg::st_coast_en;
			launch_pkg::st_resync_spd:
				nxt_state = (motor_speed > forward_catch_speed_threshold) ?
					launch_pkg::st_closed_loop :
					launch_pkg::st_open_loop;
			launch_pkg::st_rev_en:
				nxt_state = reversal_drive_enable ?
					launch_pkg::st_rev_spd : launch_pkg::st_coast_en;
			launch_pkg::st_rev_spd:
				nxt_state = (motor_speed > loop_handoff_speed) ?
					launch_pkg::st_rev_closed :
					launch_pkg::st_rev_open;
			launch_pkg::st_rev_closed:
				if (motor_speed <= loop_handoff_speed)
					nxt_state = launch_pkg::st_rev_open;
			launch_pkg::st_rev_open:
				// through zero: spin_forward flips, then speed rises
				if (spin_forward && motor_speed > loop_handoff_speed)
					nxt_state = launch_pkg::st_closed_loop;
			launch_pkg::st_coast_en:
				nxt_state = coast_enable ?
					launch_pkg::st_coast : launch_pkg::st_brake_en;
			launch_pkg::st_coast:
				if (timer_ff >= coast_duration)
					nxt_state = launch_pkg::st_brake_en;
			launch_pkg::st_brake_en:
				nxt_state = brake_enable ?
					launch_pkg::st_brake : launch_pkg::st_startup;
			launch_pkg::st_brake:
				if (timer_ff >= brake_duration)
					nxt_state = launch_pkg::st_startup;
				else if (brake_type_select &&
					settle_ff >= brake_settle_window)
					nxt_state = launch_pkg::st_startup;
			launch_pkg::st_startup:
				if (timer_ff >= `ALIGN_CYCLES && (launch_method_select !=
					`LAUNCH_DOUBLE || align_pass_ff == 2'h1))
					nxt_state = launch_pkg::st_open_loop;
			launch_pkg::st_open_loop:
				if (motor_speed > forward_catch_speed_threshold)
					nxt_state = launch_pkg::st_closed_loop;
			launch_pkg::st_closed_loop:
				nxt_state = state_ff;
			default: nxt_state = launch_pkg::st_power_on;
		endcase
		if (state_ff != launch_pkg::st_power_on) begin
			if (stopped)
				nxt_state = launch_pkg::st_sleep;
			else if (dir_change_cmd && state_ff != launch_pkg::st_sleep)
				nxt_state = reversal_path_select ?
					launch_pkg::st_rev_spd :
					launch_pkg::st_detect_en;
		end
	end

	assign enter = (nxt_state != state_ff);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			state_ff <= launch_pkg::st_power_on;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			load_cnt_ff <= 8'h0;
		else if (state_ff == launch_pkg::st_power_on &&
			load_cnt_ff != `LOAD_CYCLES)
			load_cnt_ff <= load_cnt_ff + 8'h1;
	end

	// shared timer restarts on every state change
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			timer_ff <= 16'h0;
		else if (enter)
			timer_ff <= 16'h0;
		else if (state_ff == launch_pkg::st_startup &&
			timer_ff >= `ALIGN_CYCLES)
			timer_ff <= 16'h0;
		else if (timer_ff != 16'hFFFF)
			timer_ff <= timer_ff + 16'h1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			align_pass_ff <= 2'h0;
		else if (enter)
			align_pass_ff <= 2'h0;
		else if (state_ff == launch_pkg::st_startup &&
			timer_ff >= `ALIGN_CYCLES)
			align_pass_ff <= align_pass_ff + 2'h1;
	end

	// all currents must stay low for the whole window
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			settle_ff <= 16'h0;
		else if (enter || phase_current_max >= brake_current_threshold)
			settle_ff <= 16'h0;
		else if (settle_ff != 16'hFFFF)
			settle_ff <= settle_ff + 16'h1;
	end

	////////////////////////////////////////////////////////////////////
	launch_pkg::bridge_t bridge_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			bridge_ff <= launch_pkg::bridge_off;
		else
			case (nxt_state)
				launch_pkg::st_coast: bridge_ff <= launch_pkg::bridge_off;
				launch_pkg::st_brake:
					if (brake_type_select || !brake_side_select)
						bridge_ff <= launch_pkg::bridge_low;
					else
						bridge_ff <= launch_pkg::bridge_high;
				launch_pkg::st_startup, launch_pkg::st_open_loop,
				launch_pkg::st_closed_loop, launch_pkg::st_rev_closed,
				launch_pkg::st_rev_open:
					bridge_ff <= launch_pkg::bridge_drive;
				default: bridge_ff <= launch_pkg::bridge_off;
			endcase
	end

	logic sleep_ff, standby_ff, sensing_ff;
	logic [1:0] method_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_ff <= 1'b0;
			standby_ff <= 1'b0;
		end else begin
			sleep_ff <= nxt_state == launch_pkg::st_sleep &&
				!low_power_select && !wake_ff;
			standby_ff <= nxt_state == launch_pkg::st_sleep &&
				(low_power_select || wake_ff);
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sensing_ff <= 1'b0;
		else
			sensing_ff <= (nxt_state == launch_pkg::st_sense);
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			method_ff <= `LAUNCH_ALIGN;
		else if (nxt_state == launch_pkg::st_startup && enter)
			method_ff <= launch_method_select;
	end

	assign state = state_ff;
	assign bridge_mode = bridge_ff;
	assign launch_method = method_ff;
	assign sleep_mode = sleep_ff;
	assign standby_mode = standby_ff;
	assign sensing = sensing_ff;

	////////////////////////////////////////////////////////////////////
	sequence coast_run_s;
		state_ff == launch_pkg::st_coast && timer_ff >= coast_duration &&
			!stopped && !dir_change_cmd;
	endsequence
	coast_exit_a: assert property (@(posedge clk) disable iff (!reset_n)
		coast_run_s |=> state_ff == launch_pkg::st_brake_en)
		else $error("coast did not end in brake decision");
	coast_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == launch_pkg::st_coast |-> bridge_ff ==
			launch_pkg::bridge_off)
		else $error("bridge not off during coast");
	brake_low_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == launch_pkg::st_brake && brake_type_select
		|-> bridge_ff == launch_pkg::bridge_low)
		else $error("current brake not on low side");
	brake_timeout_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == launch_pkg::st_brake && timer_ff >= brake_duration &&
		!stopped && !dir_change_cmd
		|=> state_ff == launch_pkg::st_startup)
		else $error("brake did not time out");
	sleep_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff != launch_pkg::st_power_on && stopped
		|=> state_ff == launch_pkg::st_sleep)
		else $error("not held in sleep with zero reference");
	power_on_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == launch_pkg::st_power_on && !load_done
		|=> state_ff == launch_pkg::st_power_on)
		else $error("left power-on before load");
	detect_br_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == launch_pkg::st_detect_en && !initial_detect_enable &&
		!stopped && !dir_change_cmd
		|=> state_ff == launch_pkg::st_brake_en)
		else $error("disabled sensing did not skip to brake");
	dir_path_a: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff != launch_pkg::st_power_on &&
		state_ff != launch_pkg::st_sleep && !stopped && dir_change_cmd &&
		reversal_path_select |=> state_ff == launch_pkg::st_rev_spd)
		else $error("direction change path wrong");
endmodule

//--- pkg/launch_map.svh
`ifndef LAUNCH_MAP_SVH
`define LAUNCH_MAP_SVH
`define DUTY_FULL 16'hFFFF
`define LOAD_CYCLES 8'h10
`define ALIGN_CYCLES 16'h0100
`define SEQ_CYCLES 16'h0040
`define MODE_POWER 2'h0
`define MODE_VOLTAGE 2'h1
`define MODE_CURRENT 2'h2
`define LAUNCH_ALIGN 2'h0
`define LAUNCH_DOUBLE 2'h1
`define LAUNCH_IPD 2'h2
`define LAUNCH_SLOW 2'h3
`endif

//--- pkg/launch_pkg.sv
package launch_pkg;
	typedef enum logic [4:0] {
		st_power_on, st_sleep, st_detect_en, st_sense, st_spin_dir,
		st_resync_en, st_resync_spd, st_rev_en, st_rev_spd,
		st_rev_closed, st_rev_open, st_coast_en, st_coast,
		st_brake_en, st_brake, st_startup, st_open_loop, st_closed_loop
	} seq_state_t;
	typedef enum logic [1:0] {
		bridge_drive, bridge_off, bridge_low, bridge_high
	} bridge_t;
endpackage

//--- sim/launch_sequencer_tb.sv
`timescale 1ns/1ps
module launch_sequencer_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] ref_mode, launch_method_select, launch_method;
	logic [15:0] duty_cmd, min_duty, power_full_scale, current_full_scale;
	logic [15:0] coast_duration, brake_duration, brake_settle_window;
	logic [15:0] standstill_bemf_threshold, forward_catch_speed_threshold;
	logic [15:0] loop_handoff_speed, brake_current_threshold, set_spd;
	logic [15:0] speed, phase_current_max, reference;
	logic low_power_select, speed_wake_pin, dir_change_cmd;
	logic reversal_path_select, initial_detect_enable, resync_enable;
	logic reversal_drive_enable, coast_enable, brake_enable, set_en;
	logic brake_type_select, brake_side_select, load_done, set_fwd;
	logic spin_forward, sleep_mode, standby_mode, sensing;
	launch_pkg::seq_state_t state;
	launch_pkg::bridge_t bridge_mode;
	int failures = 0;
	int checked = 0;
	logic [31:0] r = 32'h0000A98A;

	launch_sequencer dut (
		.clk, .reset_n, .ref_mode, .duty_cmd, .min_duty, .power_full_scale,
		.current_full_scale, .low_power_select, .speed_wake_pin,
		.dir_change_cmd, .reversal_path_select, .initial_detect_enable,
		.resync_enable, .reversal_drive_enable, .coast_enable, .brake_enable,
		.brake_type_select, .brake_side_select, .launch_method_select,
		.coast_duration, .brake_duration, .brake_settle_window,
		.bemf_level(speed), .standstill_bemf_threshold, .spin_forward,
		.motor_speed(speed), .forward_catch_speed_threshold,
		.loop_handoff_speed, .brake_current_threshold, .phase_current_max,
		.load_done, .reference, .state, .bridge_mode, .launch_method,
		.sleep_mode, .standby_mode, .sensing
	);
	motor_model rotor (
		.clk, .bridge_mode, .set_en, .set_speed(set_spd), .set_fwd, .speed,
		.spin_forward, .phase_current_max
	);

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// duty below minimum is raised to it in power and current modes only
	function automatic logic [15:0] exp_ref();
		logic [15:0] fs, e;
		fs = ref_mode == 2'h0 ? power_full_scale : current_full_scale;
		e = duty_cmd < min_duty ? min_duty : duty_cmd;
		if (ref_mode == 2'h1) return duty_cmd < min_duty ? 16'h0000 : duty_cmd;
		if (ref_mode == 2'h3) return 16'h0000;
		if (e == 16'hFFFF) return fs;
		return 16'((32'(e) * 32'(fs)) >> 16);
	endfunction
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_st(launch_pkg::seq_state_t s, int lim);
		int n;
		n = 0;
		while (state !== s && n < lim) begin
			cyc(1);
			n++;
		end
		chk("state", s, state);
	endtask
	// length of the current state, with the bridge pattern it holds
	task automatic span(launch_pkg::bridge_t b, int d);
		int n;
		launch_pkg::seq_state_t s;
		s = state;
		n = 0;
		chk("bridge", b, bridge_mode);
		while (state === s && n < 2000) begin
			cyc(1);
			n++;
		end
		checked++;
		if (n < d - 1 || n > d + 2) begin
			failures++;
			$display("CHECK FAILED span expected %0d seen %0d", d, n);
		end
	endtask
	// back to rest, then preset the rotor and restart
	task automatic run(logic [15:0] spd, logic fw);
		@(posedge clk);
		duty_cmd <= 16'h0000;
		wait_st(launch_pkg::st_sleep, 40);
		@(posedge clk);
		set_en <= 1'b1;
		set_spd <= spd;
		set_fwd <= fw;
		duty_cmd <= 16'h8000;
		@(posedge clk);
		set_en <= 1'b0;
		#1;
	endtask
	task automatic wrap_up();
		if (failures == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		failures++;
		wrap_up();
	end

	initial begin
		launch_pkg::bridge_t bb;
		int dd;
		{low_power_select, speed_wake_pin, dir_change_cmd, reversal_path_select,
			initial_detect_enable, resync_enable, reversal_drive_enable,
			coast_enable, brake_enable, brake_type_select, brake_side_select,
			load_done, set_fwd} = '0;
		set_en = 1'b1;
		set_spd = 16'h0000;
		ref_mode = 2'h1;
		launch_method_select = 2'h0;
		duty_cmd = 16'h0000;
		min_duty = 16'h1000;
		power_full_scale = 16'h4000;
		current_full_scale = 16'h2000;
		coast_duration = 16'h0028;
		brake_duration = 16'h001E;
		brake_settle_window = 16'h0005;
		standstill_bemf_threshold = 16'h0064;
		forward_catch_speed_threshold = 16'h03E8;
		loop_handoff_speed = 16'h03E8;
		brake_current_threshold = 16'h0000;
		cyc(2);
		chk("state", launch_pkg::st_power_on, state);
		chk("bridge", launch_pkg::bridge_off, bridge_mode);
		chk("reference", 0, reference);
		@(posedge clk);
		reset_n <= 1'b1;
		set_en <= 1'b0;
		cyc(30);
		chk("state", launch_pkg::st_power_on, state);
		load_done <= 1'b1;
		wait_st(launch_pkg::st_sleep, 40);
		// wake pin high gives standby even with sleep selected
		for (int k = 0; k < 3; k++) begin
			low_power_select <= k == 1;
			speed_wake_pin <= k == 2;
			cyc(6);
			chk("sleep", k == 0, sleep_mode);
			chk("standby", k != 0, standby_mode);
		end
		for (int i = 0; i < 40; i++) begin
			r = lfsr(r);
			duty_cmd <= i < 4 ? 16'hFFFF : r[15:0];
			min_duty <= r[31:16];
			r = lfsr(r);
			ref_mode <= i < 4 ? i[1:0] : r[1:0];
			power_full_scale <= i % 4 == 1 ? 16'h0000 : r[31:16];
			current_full_scale <= r[17:2];
			cyc(2);
			chk("reference", exp_ref(), reference);
		end
		ref_mode <= 2'h0;
		power_full_scale <= 16'h0000;
		duty_cmd <= 16'h8000;
		wait_st(launch_pkg::st_sleep, 40);
		cyc(20);
		chk("state", launch_pkg::st_sleep, state);
		ref_mode <= 2'h1;
		min_duty <= 16'h1000;
		for (int m = 0; m < 4; m++) begin
			launch_method_select <= m[1:0];
			run(16'h0000, 1'b1);
			wait_st(launch_pkg::st_detect_en, 4);
			wait_st(launch_pkg::st_brake_en, 4);
			wait_st(launch_pkg::st_startup, 4);
			chk("method", m, launch_method);
			// double align runs two full align passes
			span(launch_pkg::bridge_drive, m == 1 ? 514 : 257);
			wait_st(launch_pkg::st_open_loop, 2);
		end
		initial_detect_enable <= 1'b1;
		run(16'h0000, 1'b1);
		wait_st(launch_pkg::st_sense, 4);
		chk("sensing", 1, sensing);
		wait_st(launch_pkg::st_brake_en, 6);
		for (int k = 0; k < 4; k++) begin
			coast_enable <= k == 0;
			brake_enable <= 1'b1;
			brake_type_select <= k == 1 || k == 2;
			brake_side_select <= k != 3;
			brake_current_threshold <= k == 2 ? 16'hFFFF : 16'h0000;
			bb = k == 0 ? launch_pkg::bridge_high : launch_pkg::bridge_low;
			dd = k == 2 ? 5 : 30;
			run(16'h07D0, 1'b0);
			wait_st(launch_pkg::st_rev_en, 8);
			if (k == 0) begin
				wait_st(launch_pkg::st_coast, 4);
				span(launch_pkg::bridge_off, 40);
				chk("state", launch_pkg::st_brake_en, state);
			end
			wait_st(launch_pkg::st_brake, 4);
			span(bb, dd);
		end
		resync_enable <= 1'b1;
		run(16'h0BB8, 1'b1);
		wait_st(launch_pkg::st_closed_loop, 10);
		run(16'h01F4, 1'b1);
		wait_st(launch_pkg::st_open_loop, 10);
		resync_enable <= 1'b0;
		run(16'h0BB8, 1'b1);
		wait_st(launch_pkg::st_coast_en, 10);
		resync_enable <= 1'b1;
		reversal_drive_enable <= 1'b1;
		run(16'h04B0, 1'b0);
		wait_st(launch_pkg::st_rev_closed, 10);
		wait_st(launch_pkg::st_rev_open, 400);
		wait_st(launch_pkg::st_closed_loop, 3000);
		for (int k = 0; k < 2; k++) begin
			reversal_path_select <= k[0];
			wait_st(launch_pkg::st_closed_loop, 40);
			@(posedge clk);
			dir_change_cmd <= 1'b1;
			@(posedge clk);
			dir_change_cmd <= 1'b0;
			#1;
			wait_st(k ? launch_pkg::st_rev_spd : launch_pkg::st_detect_en, 3);
		end
		wrap_up();
	end
endmodule

//--- sim/motor_model.sv
`timescale 1ns/1ps
module motor_model (
	// clock
	input wire logic clk,
	// bridge
	input wire launch_pkg::bridge_t bridge_mode,
	// preset from the bench
	input wire logic set_en,
	input wire logic [15:0] set_speed,
	input wire logic set_fwd,
	// sensed quantities
	output logic [15:0] speed,
	output logic spin_forward,
	output logic [15:0] phase_current_max
);
	////////////////////////////////////////////////////////////////////////
	// only forward drive speeds it up; a reversed rotor slows, then turns
	always_ff @(posedge clk) begin
		if (set_en) begin
			speed <= set_speed;
			spin_forward <= set_fwd;
		end else if (bridge_mode == launch_pkg::bridge_drive && spin_forward) begin
			if (speed != 16'hFFFF) speed <= speed + 16'h0001;
		end else if (speed == 16'h0000) begin
			spin_forward <= 1'b1;
		end else begin
			speed <= speed - 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// current flows only while shorted by a brake
	assign phase_current_max = (bridge_mode == launch_pkg::bridge_low ||
		bridge_mode == launch_pkg::bridge_high) ? speed : 16'h0000;
endmodule
